/* File: verilog/merit_regs.svh */
// Purpose: Offsets, field positions and reset values of the error rate monitor
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Included by its bare name
`ifndef MERIT_REGS_SVH
`define MERIT_REGS_SVH

`define REG_ADDR_W       8
`define REG_STATUS_OFF   8'h00
`define REG_MASK_OFF     8'h04
`define REG_MONITOR_OFF  8'h08

`define IRQ_INC_BIT      0
`define IRQ_DEC_BIT      1
`define IRQ_W            2
`define IRQ_RST          2'h0
`define MASK_RST         2'h0

`define MON_MERIT_LSB    0
`define MON_MODE_BIT     8
`define MON_BAD_LSB      12
`define MON_GOOD_LSB     16

`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2

`endif

/* File: verilog/merit_pkg.sv */
// Purpose: Types shared by the error rate monitor
// Assumes: Receiver events are one-cycle pulses
// Notes:   Register constants live in merit_regs.svh
package merit_pkg;

	typedef enum logic {mode_normal, mode_octet} mon_mode_e;

	typedef struct packed {
		logic abort;
		logic long_frame_error;
		logic short_frame_error;
		logic align_error;
		logic crc_error;
		logic octet_strobe;
		logic msg_done;
	} rx_event_s;

	typedef enum logic [1:0] {sel_status, sel_mask, sel_monitor, sel_none} reg_sel_e;

endpackage : merit_pkg

/* File: verilog/error_rate_monitor.sv */
// Purpose: Leaky-bucket signal unit error rate monitor with AXI4-Lite registers
// Assumes: Receiver event pulses synchronous to aclk
// Notes:   Figure of merit saturates at both ends
//
// Contract
// - Abort enters octet counting mode
// - Long frame error enters octet counting mode
// - Count every octet while in octet mode; here a strobe in the same cycle as the exiting good message is not counted
// - Bad-octet wrap raises merit by one
// - Only an unerrored message leaves octet mode
// - Clear bad-octet counter on each entry
// - Unerrored means no frame, align, CRC error
// - Each unerrored message bumps good counter
// - Good counter wrap lowers merit by one
// - Good counter frozen during octet mode
// - Each decrement raises a decrement event
// - Figure of merit is six bits wide
// - Short, align or CRC error raises merit
// - Each increment raises an increment event
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "merit_regs.svh"
`timescale 1ns/1ps

module error_rate_monitor
	import merit_pkg::*;
#(
	parameter int MERIT_W = 6,
	parameter int BAD_W   = 4,
	parameter int GOOD_W  = 8
)(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire rx_event_s              rx_event,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic [MERIT_W-1:0]          error_rate_figure_of_merit,
	output logic                        irq
);

	localparam logic [MERIT_W-1:0] MERIT_MAX = {MERIT_W{1'b1}};
	localparam logic [BAD_W-1:0]   BAD_MAX   = {BAD_W{1'b1}};
	localparam logic [GOOD_W-1:0]  GOOD_MAX  = {GOOD_W{1'b1}};

	function automatic reg_sel_e reg_sel(input logic [`REG_ADDR_W-1:0] addr);
		case (addr)
			`REG_STATUS_OFF:  reg_sel = sel_status;
			`REG_MASK_OFF:    reg_sel = sel_mask;
			`REG_MONITOR_OFF: reg_sel = sel_monitor;
			default:          reg_sel = sel_none;
		endcase
	endfunction : reg_sel

	mon_mode_e          mode_r, mode_nxt;
	logic [BAD_W-1:0]   bad_r, bad_nxt;
	logic [GOOD_W-1:0]  good_r, good_nxt;
	logic [MERIT_W-1:0] merit_r, merit_nxt;
	logic [`IRQ_W-1:0]  status_r, status_nxt;
	logic [`IRQ_W-1:0]  mask_r, mask_nxt;
	logic               good_msg;
	logic               err_any;
	logic               enter;
	logic               bad_wrap;
	logic               good_wrap;
	logic               inc_req;
	logic               dec_req;
	logic               inc_evt;
	logic               dec_evt;

	// Long frame is an error but counts only through octet mode
	assign good_msg = rx_event.msg_done & ~(rx_event.short_frame_error
		| rx_event.long_frame_error | rx_event.align_error | rx_event.crc_error);
	assign err_any  = rx_event.short_frame_error | rx_event.align_error
		| rx_event.crc_error;
	assign enter    = rx_event.abort | rx_event.long_frame_error;

	always_comb
	begin
		mode_nxt  = mode_r;
		bad_nxt   = bad_r;
		good_nxt  = good_r;
		bad_wrap  = 1'b0;
		good_wrap = 1'b0;
		case (mode_r)
			mode_normal:
			begin
				if (enter)
				begin
					mode_nxt = mode_octet;
					bad_nxt  = '0;
				end
				else if (good_msg)
				begin
					good_nxt  = good_r + GOOD_W'(1);
					good_wrap = (good_r == GOOD_MAX);
				end
			end
			mode_octet:
			begin
				// Exiting message is not counted as good; counter stays frozen
				if (good_msg)
					mode_nxt = mode_normal;
				else if (rx_event.octet_strobe)
				begin
					bad_nxt  = bad_r + BAD_W'(1);
					bad_wrap = (bad_r == BAD_MAX);
				end
			end
			default:
				mode_nxt = mode_normal;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_r <= mode_normal;
			bad_r  <= '0;
			good_r <= '0;
		end
		else
		begin
			mode_r <= mode_nxt;
			bad_r  <= bad_nxt;
			good_r <= good_nxt;
		end
	end

	assign inc_req = err_any | bad_wrap;
	assign dec_req = good_wrap;

	// Coincident raise and lower cancel, so no event for either
	always_comb
	begin
		merit_nxt = merit_r;
		inc_evt   = 1'b0;
		dec_evt   = 1'b0;
		if (inc_req && !dec_req && merit_r != MERIT_MAX)
		begin
			merit_nxt = merit_r + MERIT_W'(1);
			inc_evt   = 1'b1;
		end
		else if (dec_req && !inc_req && merit_r != '0)
		begin
			merit_nxt = merit_r - MERIT_W'(1);
			dec_evt   = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			merit_r <= '0;
		else
			merit_r <= merit_nxt;
	end

	assign error_rate_figure_of_merit = merit_r;

	// AXI4-Lite slave
	logic                   aw_got_r, aw_got_nxt;
	logic                   w_got_r, w_got_nxt;
	logic [`REG_ADDR_W-1:0] waddr_r, waddr_nxt;
	logic [31:0]            wdata_r, wdata_nxt;
	logic                   wstrb0_r, wstrb0_nxt;
	logic                   bvalid_r, bvalid_nxt;
	logic [1:0]             bresp_r, bresp_nxt;
	logic                   rvalid_r, rvalid_nxt;
	logic [31:0]            rdata_r, rdata_nxt;
	logic [1:0]             rresp_r, rresp_nxt;
	logic                   do_write;
	reg_sel_e               wsel;
	reg_sel_e               rsel;

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign do_write      = aw_got_r & w_got_r;
	assign wsel          = reg_sel(waddr_r);
	assign rsel          = reg_sel(s_axi_araddr);

	always_comb
	begin
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		waddr_nxt  = waddr_r;
		wdata_nxt  = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_nxt = 1'b1;
			waddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_nxt  = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb0_nxt = s_axi_wstrb[0];
		end
		if (do_write)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = (wsel == sel_none) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
		end
		else if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = '0;
			rresp_nxt  = `AXI_RESP_OKAY;
			case (rsel)
				sel_status:
					rdata_nxt[`IRQ_W-1:0] = status_r;
				sel_mask:
					rdata_nxt[`IRQ_W-1:0] = mask_r;
				sel_monitor:
				begin
					rdata_nxt[`MON_MERIT_LSB +: MERIT_W] = merit_r;
					rdata_nxt[`MON_MODE_BIT]             = (mode_r == mode_octet);
					rdata_nxt[`MON_BAD_LSB +: BAD_W]     = bad_r;
					rdata_nxt[`MON_GOOD_LSB +: GOOD_W]   = good_r;
				end
				default:
					rresp_nxt = `AXI_RESP_SLVERR;
			endcase
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			waddr_r  <= '0;
			wdata_r  <= '0;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= `AXI_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= `AXI_RESP_OKAY;
		end
		else
		begin
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			waddr_r  <= waddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	// Interrupt status: new event beats a same-cycle write-one-to-clear
	logic [`IRQ_W-1:0] evt_set;
	logic [`IRQ_W-1:0] w1c;

	always_comb
	begin
		evt_set                = '0;
		evt_set[`IRQ_INC_BIT]  = inc_evt;
		evt_set[`IRQ_DEC_BIT]  = dec_evt;
		w1c                    = '0;
		mask_nxt               = mask_r;
		if (do_write && wstrb0_r && wsel == sel_status)
			w1c = wdata_r[`IRQ_W-1:0];
		if (do_write && wstrb0_r && wsel == sel_mask)
			mask_nxt = wdata_r[`IRQ_W-1:0];
		status_nxt = (status_r & ~w1c) | evt_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_r <= `IRQ_RST;
			mask_r   <= `MASK_RST;
		end
		else
		begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
		end
	end

	assign irq = |(status_r & mask_r);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_abort_enters: assert property (mode_r == mode_normal && rx_event.abort
		|=> mode_r == mode_octet && bad_r == '0)
		else $error("abort did not enter octet mode");
	a_long_enters: assert property (mode_r == mode_normal
		&& rx_event.long_frame_error |=> mode_r == mode_octet)
		else $error("long frame did not enter octet mode");
	a_octet_count: assert property (mode_r == mode_octet && !good_msg
		&& rx_event.octet_strobe |=> bad_r == $past(bad_r) + BAD_W'(1))
		else $error("bad octet not counted");
	a_bad_wrap_inc: assert property (mode_r == mode_octet && !good_msg
		&& rx_event.octet_strobe && bad_r == BAD_MAX && !dec_req
		&& merit_r != MERIT_MAX |=> merit_r == $past(merit_r) + MERIT_W'(1))
		else $error("bad octet wrap did not raise merit");
	a_octet_stays: assert property (mode_r == mode_octet && !good_msg
		|=> mode_r == mode_octet)
		else $error("octet mode left without good message");
	a_good_exits: assert property (mode_r == mode_octet && good_msg
		|=> mode_r == mode_normal && good_r == $past(good_r))
		else $error("good message did not leave octet mode");
	a_err_not_good: assert property (rx_event.crc_error || rx_event.align_error
		|| rx_event.short_frame_error || rx_event.long_frame_error |-> !good_msg)
		else $error("errored message taken as good");
	a_good_count: assert property (mode_r == mode_normal && good_msg && !enter
		|=> good_r == $past(good_r) + GOOD_W'(1))
		else $error("good message not counted");
	a_good_frozen: assert property (mode_r == mode_octet
		|=> good_r == $past(good_r))
		else $error("good counter moved in octet mode");
	a_good_wrap_dec: assert property (good_wrap && !inc_req && merit_r != '0
		|=> merit_r == $past(merit_r) - MERIT_W'(1) ##0 status_r[`IRQ_DEC_BIT])
		else $error("good wrap did not lower merit");
	a_err_inc: assert property (err_any && !dec_req && merit_r != MERIT_MAX
		|=> merit_r == $past(merit_r) + MERIT_W'(1))
		else $error("error did not raise merit");
	a_inc_irq: assert property (merit_nxt > merit_r
		|=> status_r[`IRQ_INC_BIT])
		else $error("increment event missing");
	a_merit_sat: assert property (merit_r == MERIT_MAX && inc_req
		|=> merit_r == MERIT_MAX && $past(!inc_evt))
		else $error("merit wrapped at maximum");

	c_octet_wrap: cover property (mode_r == mode_octet && bad_wrap);
	c_good_wrap: cover property (good_wrap && merit_r != '0);
	c_exit_octet: cover property (mode_r == mode_octet ##1 mode_r == mode_normal);
	c_irq_rise: cover property (!irq ##1 irq);

endmodule : error_rate_monitor

/* File: testbench/rx_proc_model.sv */
// Purpose: Receive message processor stand-in driving event pulses
// Assumes: Each event group is one cycle wide
// Notes:   Idle cycle between pulses keeps repeated events distinct
`timescale 1ns/1ps

module rx_proc_model
	import merit_pkg::*;
(
	input  wire logic aclk,
	output rx_event_s rx_event
);
	initial rx_event = '0;

	// Gap models a slow receiver; zero gives the fastest legal rate
	task automatic fire(input rx_event_s e, input int n, input int gap);
		repeat (n)
		begin
			@(posedge aclk);
			rx_event <= e;
			@(posedge aclk);
			rx_event <= '0;
			repeat (gap) @(posedge aclk);
		end
	endtask : fire
endmodule : rx_proc_model

/* File: testbench/signal_unit_error_rate_monitor_bench.sv */
// Purpose: Self-checking bench for the error rate monitor
// Assumes: Register map and fields from merit_regs.svh
// Notes:   Ready and valid are sampled at the falling edge, settled before the taking edge
`include "merit_regs.svh"
`timescale 1ns/1ps

module signal_unit_error_rate_monitor_bench
	import merit_pkg::*;
;
	localparam rx_event_s ev_good = 7'h01;
	localparam rx_event_s ev_oct  = 7'h02;
	localparam rx_event_s ev_crc  = 7'h04;
	localparam rx_event_s ev_long = 7'h20;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	rx_event_s   rx_event;
	logic        awv = 1'b0, awr, wv = 1'b0, wrdy, bv, br = 1'b0;
	logic        arv = 1'b0, arr, rv, rr = 1'b0, irq;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic [3:0]  ws = 4'h0;
	logic [1:0]  bp, rp, r;
	logic [5:0]  merit;
	int          fails = 0, total_checks = 0, cycles = 0;

	always #4 aclk = ~aclk;

	rx_proc_model rx (.aclk(aclk), .rx_event(rx_event));

	error_rate_monitor dut (
		.aclk(aclk), .aresetn(aresetn), .rx_event(rx_event),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rp),
		.error_rate_figure_of_merit(merit), .irq(irq)
	);

	task automatic wrap_up;
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ga, gw, gb;
		int   n;
		n = 0;
		gb = 1'b0;
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= v;
		ws <= 4'hf;
		br <= 1'b1;
		while (!gb && n < 64)
		begin
			@(negedge aclk);
			ga = awv && awr;
			gw = wv && wrdy;
			gb = bv;
			r = bp;
			n++;
			@(posedge aclk);
			if (ga)
				awv <= 1'b0;
			if (gw)
				wv <= 1'b0;
		end
		br <= 1'b0;
		if (!gb)
			fails++;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ga, gr;
		int   n;
		n = 0;
		gr = 1'b0;
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		while (!gr && n < 64)
		begin
			@(negedge aclk);
			ga = arv && arr;
			gr = rv;
			d = rdat;
			r = rp;
			n++;
			@(posedge aclk);
			if (ga)
				arv <= 1'b0;
		end
		rr <= 1'b0;
		if (!gr)
			fails++;
	endtask : rd

	task automatic mon(input logic [5:0] m, input logic md, input logic [3:0] b,
		input logic [7:0] g);
		rd(`REG_MONITOR_OFF);
		chk(d, (32'(g) << `MON_GOOD_LSB) | (32'(b) << `MON_BAD_LSB)
			| (32'(md) << `MON_MODE_BIT) | 32'(m));
		chk(32'(merit), 32'(m));
	endtask : mon

	task automatic st(input logic [1:0] exp);
		rd(`REG_STATUS_OFF);
		chk(d, 32'(exp));
	endtask : st

	// Hang guard, sized well above the roughly 1300 cycles the run needs
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			fails++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		mon(6'h00, 1'b0, 4'h0, 8'h00);
		st(2'h0);
		rd(8'h0c);
		chk(32'(r), 32'(`AXI_RESP_SLVERR));
		wr(8'h10, 32'h3);
		chk(32'(r), 32'(`AXI_RESP_SLVERR));
		rx.fire(ev_good, 256, 0);
		mon(6'h00, 1'b0, 4'h0, 8'h00);
		st(2'h0);
		rx.fire(ev_good, 3, 2);
		mon(6'h00, 1'b0, 4'h0, 8'h03);
		rx.fire(ev_crc, 1, 0);
		rx.fire(7'h10, 1, 0);
		rx.fire(7'h08, 1, 0);
		mon(6'h03, 1'b0, 4'h0, 8'h03);
		chk(32'(irq), 32'h0);
		wr(`REG_MASK_OFF, 32'h1);
		rd(`REG_MASK_OFF);
		chk(d, 32'h1);
		chk(32'(irq), 32'h1);
		wr(`REG_STATUS_OFF, 32'h3);
		st(2'h0);
		chk(32'(irq), 32'h0);
		rx.fire(7'h40, 1, 0);
		mon(6'h03, 1'b1, 4'h0, 8'h03);
		rx.fire(ev_oct, 15, 0);
		mon(6'h03, 1'b1, 4'hf, 8'h03);
		rx.fire(ev_oct, 1, 0);
		mon(6'h04, 1'b1, 4'h0, 8'h03);
		st(2'h1);
		rx.fire(ev_good, 1, 0);
		mon(6'h04, 1'b0, 4'h0, 8'h03);
		rx.fire(ev_long, 1, 0);
		rx.fire(ev_oct, 5, 0);
		rx.fire(7'h05, 1, 0);
		mon(6'h05, 1'b1, 4'h5, 8'h03);
		rx.fire(ev_good, 1, 0);
		rx.fire(ev_long, 1, 0);
		mon(6'h05, 1'b1, 4'h0, 8'h03);
		rx.fire(ev_good, 1, 0);
		rx.fire(ev_good, 252, 0);
		mon(6'h05, 1'b0, 4'h0, 8'hff);
		wr(`REG_STATUS_OFF, 32'h3);
		rx.fire(ev_good, 1, 0);
		mon(6'h04, 1'b0, 4'h0, 8'h00);
		st(2'h2);
		rx.fire(ev_crc, 59, 0);
		mon(6'h3f, 1'b0, 4'h0, 8'h00);
		wr(`REG_STATUS_OFF, 32'h3);
		rx.fire(ev_crc, 1, 0);
		mon(6'h3f, 1'b0, 4'h0, 8'h00);
		st(2'h0);
		wrap_up();
	end
endmodule : signal_unit_error_rate_monitor_bench
